// [flash_prot_pkg.sv]
// flash_prot_pkg: constants and carrier types for the flash configuration
// and range protection registers; assumes a 16-bit flash address map.
//
// How it works
// - config bits 7..5 writable, others read zero
// - key access writable only with backdoor enabled
// - buffer empty enable gates buffer empty interrupt
// - complete enable gates completion interrupt
// - key access reroutes array writes, invalidates reads
// - polarity bit only clears, never sets
// - lower size frozen once lower disable cleared
// - upper size frozen once upper disable cleared
// - protection byte loaded from array after reset
// - protected program or erase refused, violation flagged
// - mass erase needs all protection disabled
// - polarity swaps meaning of range disable bits
// - upper disable bit five enables upper range
// - lower disable bit two enables lower range
// - disallowed scenario write ignored in full
// - upper range 2/4/8/16 KB ending at top
// - lower range 1/2/4/8 KB from 0x4000
package flash_prot_pkg;

    // ========================================================
    // register map (printed offsets are word indices)
    localparam logic [7:0]  CONFIG_INDEX   = 8'h03;
    localparam logic [7:0]  PROTECT_INDEX  = 8'h04;
    localparam logic [7:0]  CONFIG_ADDR    = 8'(CONFIG_INDEX * 4);
    localparam logic [7:0]  PROTECT_ADDR   = 8'(PROTECT_INDEX * 4);

    // ========================================================
    // configuration register fields
    localparam int          BUF_EMPTY_IRQ_EN_BIT = 7;
    localparam int          COMPLETE_IRQ_EN_BIT  = 6;
    localparam int          KEY_ACCESS_EN_BIT    = 5;
    localparam logic [7:0]  CONFIG_RESET         = 8'h00;
    localparam logic [1:0]  BACKDOOR_ENABLED     = 2'b10;

    // ========================================================
    // protection register fields
    localparam int          POLARITY_BIT      = 7;
    localparam int          SPARE_NV_BIT      = 6;
    localparam int          UPPER_DISABLE_BIT = 5;
    localparam int          UPPER_SIZE_HI     = 4;
    localparam int          UPPER_SIZE_LO     = 3;
    localparam int          LOWER_DISABLE_BIT = 2;
    localparam int          LOWER_SIZE_HI     = 1;
    localparam int          LOWER_SIZE_LO     = 0;
    localparam logic [7:0]  PROTECT_RESET     = 8'hff;

    // ========================================================
    // address ranges
    localparam logic [16:0] ARRAY_TOP_END     = 17'h1_0000;
    localparam logic [16:0] UPPER_BASE_SIZE   = 17'h0_0800;
    localparam logic [16:0] LOWER_START       = 17'h0_4000;
    localparam logic [16:0] LOWER_BASE_SIZE   = 17'h0_0400;

    // ========================================================
    // carrier types
    typedef struct packed {
        logic        polarity;
        logic        spareNv;
        logic        upperDisable;
        logic [1:0]  upperSize;
        logic        lowerDisable;
        logic [1:0]  lowerSize;
    } protect_reg_type;

    typedef struct packed {
        logic        valid;
        logic        massErase;
        logic [15:0] addr;
    } cmd_request_type;

    typedef struct packed {
        logic        accept;
        logic        violation;
    } cmd_result_type;

    typedef enum logic [0:0] {
        LOAD_PROTECT = 1'b0,
        RUNNING      = 1'b1
    } ctrl_state_type;

endpackage

// [flash_range_check.sv]
// flash_range_check: decides whether one flash address is protected
// under a given protection register value; purely combinational and
// assumes a 16-bit address space with the array top at 0xffff.
`timescale 1ns/1ps

module flash_range_check
(
    // protection setting
    input  wire flash_prot_pkg::protect_reg_type protect,
    // address under test
    input  wire logic [15:0]                     addr,
    // verdict
    output logic                                 isProtected
);

    logic [16:0] upperStart;
    logic [16:0] lowerEnd;
    logic [16:0] addrWide;
    logic        inUpper;
    logic        inLower;

    // ========================================================
    // range bounds from the size codes
    assign upperStart = flash_prot_pkg::ARRAY_TOP_END
                      - (flash_prot_pkg::UPPER_BASE_SIZE << protect.upperSize);
    assign lowerEnd   = flash_prot_pkg::LOWER_START
                      + (flash_prot_pkg::LOWER_BASE_SIZE << protect.lowerSize);
    assign addrWide   = {1'b0, addr};

    // a range only counts while its disable bit is clear
    assign inUpper = !protect.upperDisable && (addrWide >= upperStart);
    assign inLower = !protect.lowerDisable
                   && (addrWide >= flash_prot_pkg::LOWER_START)
                   && (addrWide < lowerEnd);

    // polarity set: ranges are protected; clear: ranges are the only holes
    assign isProtected = protect.polarity ? (inUpper || inLower)
                                          : !(inUpper || inLower);

endmodule // flash_range_check

// [flash_config_protection_regs.sv]
// flash_config_protection_regs: configuration and range protection
// registers of the flash module behind an APB slave, plus the checks
// that gate program, erase and array access on them.
// assumes all non-bus inputs come from logic on clk, and that the
// stored protection byte is valid as soon as reset is released.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module flash_config_protection_regs
(
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    // apb slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [7:0]                      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic                                 pready,
    output logic [31:0]                          prdata,
    output logic                                 pslverr,
    // neighbouring flash state
    input  wire logic [1:0]                      backdoorEnableField,
    input  wire logic                            bufferEmptyFlag,
    input  wire logic                            allCompleteFlag,
    input  wire logic [7:0]                      storedProtectByte,
    // interrupt requests
    output logic                                 bufferEmptyIrq,
    output logic                                 completeIrq,
    // array access routing
    input  wire logic                            arrayWrite,
    output logic                                 keyWordWrite,
    output logic                                 cmdSequenceStart,
    output logic                                 readDataInvalid,
    // program and erase requests
    input  wire flash_prot_pkg::cmd_request_type cmdRequest,
    output flash_prot_pkg::cmd_result_type       cmdResult,
    // register values; configValue lags the register by one cycle
    output logic [7:0]                           configValue,
    output flash_prot_pkg::protect_reg_type      protectValue
);

    // ========================================================
    // internal state
    flash_prot_pkg::ctrl_state_type  state;
    flash_prot_pkg::protect_reg_type protect;
    flash_prot_pkg::protect_reg_type next_protect;
    flash_prot_pkg::protect_reg_type writeProtect;
    logic                            bufferEmptyIrqEn;
    logic                            completeIrqEn;
    logic                            keyAccessEn;
    logic [7:0]                      configRead;
    logic                            setupPhase;
    logic                            writeStrobe;
    logic                            addrHitConfig;
    logic                            addrHitProtect;
    logic                            addrMapped;
    logic                            scenarioLegal;
    logic                            cmdProtected;
    logic                            massEraseAllowed;

    // ========================================================
    // bus decode
    assign setupPhase     = psel && !penable && (state == flash_prot_pkg::RUNNING);
    assign writeStrobe    = psel && penable && pready && pwrite;
    assign addrHitConfig  = (paddr == flash_prot_pkg::CONFIG_ADDR);
    assign addrHitProtect = (paddr == flash_prot_pkg::PROTECT_ADDR);
    assign addrMapped     = addrHitConfig || addrHitProtect;

    // read view of the configuration register, unused bits read zero
    always_comb
    begin
        configRead = 8'h00;
        configRead[flash_prot_pkg::BUF_EMPTY_IRQ_EN_BIT] = bufferEmptyIrqEn;
        configRead[flash_prot_pkg::COMPLETE_IRQ_EN_BIT]  = completeIrqEn;
        configRead[flash_prot_pkg::KEY_ACCESS_EN_BIT]    = keyAccessEn;
    end

    // ========================================================
    // reset load sequence: one cycle to fetch the protection byte
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state <= flash_prot_pkg::LOAD_PROTECT;
        else
            state <= flash_prot_pkg::RUNNING;
    end

    // ========================================================
    // apb answer: zero wait states, ready in the first access cycle
    // bus is held off during the load so software never sees a stale value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !addrMapped;
            if (setupPhase && !pwrite && addrHitConfig)
                prdata <= {24'h00_0000, configRead};
            else if (setupPhase && !pwrite && addrHitProtect)
                prdata <= {24'h00_0000, protect};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // ========================================================
    // configuration register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bufferEmptyIrqEn <= flash_prot_pkg::CONFIG_RESET[7];
            completeIrqEn    <= flash_prot_pkg::CONFIG_RESET[6];
            keyAccessEn      <= flash_prot_pkg::CONFIG_RESET[5];
        end
        else if (writeStrobe && addrHitConfig)
        begin
            bufferEmptyIrqEn <= pwdata[flash_prot_pkg::BUF_EMPTY_IRQ_EN_BIT];
            completeIrqEn    <= pwdata[flash_prot_pkg::COMPLETE_IRQ_EN_BIT];
            // key access is locked unless the backdoor is enabled
            if (backdoorEnableField == flash_prot_pkg::BACKDOOR_ENABLED)
                keyAccessEn <= pwdata[flash_prot_pkg::KEY_ACCESS_EN_BIT];
        end
    end

    // ========================================================
    // protection write candidate: per-field write locks
    always_comb
    begin
        writeProtect = protect;
        // polarity may only fall; a set attempt keeps the old value
        writeProtect.polarity = protect.polarity
                              && pwdata[flash_prot_pkg::POLARITY_BIT];
        writeProtect.upperDisable = pwdata[flash_prot_pkg::UPPER_DISABLE_BIT];
        writeProtect.lowerDisable = pwdata[flash_prot_pkg::LOWER_DISABLE_BIT];
        if (protect.upperDisable)
            writeProtect.upperSize =
                pwdata[flash_prot_pkg::UPPER_SIZE_HI:flash_prot_pkg::UPPER_SIZE_LO];
        if (protect.lowerDisable)
            writeProtect.lowerSize =
                pwdata[flash_prot_pkg::LOWER_SIZE_HI:flash_prot_pkg::LOWER_SIZE_LO];
    end

    // scenario check: protection may only grow, never shrink
    always_comb
    begin
        if (protect.polarity && writeProtect.polarity)
            // protected ranges: a disable bit may only fall, never rise
            scenarioLegal = (!writeProtect.upperDisable || protect.upperDisable)
                         && (!writeProtect.lowerDisable || protect.lowerDisable);
        else if (!protect.polarity)
            // unprotected holes: a disable bit may only rise
            scenarioLegal = (writeProtect.upperDisable >= protect.upperDisable)
                         && (writeProtect.lowerDisable >= protect.lowerDisable);
        else
            // polarity falling: a new hole may not open over a protected range
            scenarioLegal = (writeProtect.upperDisable || protect.upperDisable)
                         && (writeProtect.lowerDisable || protect.lowerDisable);
    end

    // ========================================================
    // protection register: loaded from the array, then guarded writes
    always_comb
    begin
        next_protect = protect;
        if (state == flash_prot_pkg::LOAD_PROTECT)
            next_protect = storedProtectByte;
        else if (writeStrobe && addrHitProtect && scenarioLegal)
            next_protect = writeProtect;
    end

    // reset holds the fully open value until the load cycle replaces it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            protect <= flash_prot_pkg::PROTECT_RESET;
        else
            protect <= next_protect;
    end

    // ========================================================
    // interrupt requests follow enable and flag with one cycle of delay
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bufferEmptyIrq <= 1'b0;
            completeIrq    <= 1'b0;
        end
        else
        begin
            bufferEmptyIrq <= bufferEmptyIrqEn && bufferEmptyFlag;
            completeIrq    <= completeIrqEn && allCompleteFlag;
        end
    end

    // ========================================================
    // array access routing by key access mode
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            keyWordWrite     <= 1'b0;
            cmdSequenceStart <= 1'b0;
            readDataInvalid  <= 1'b0;
        end
        else
        begin
            keyWordWrite     <= arrayWrite && keyAccessEn;
            cmdSequenceStart <= arrayWrite && !keyAccessEn;
            readDataInvalid  <= keyAccessEn;
        end
    end

    // ========================================================
    // program and erase gating
    flash_range_check u_range_check
    (
        .protect     (protect),
        .addr        (cmdRequest.addr),
        .isProtected (cmdProtected)
    );

    assign massEraseAllowed = protect.polarity && protect.upperDisable
                            && protect.lowerDisable;

    // one result pulse per request; the status flag itself lives elsewhere
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cmdResult <= '0;
        else if (!cmdRequest.valid || state != flash_prot_pkg::RUNNING)
            cmdResult <= '0;
        else if (cmdRequest.massErase)
        begin
            cmdResult.accept    <= massEraseAllowed;
            cmdResult.violation <= !massEraseAllowed;
        end
        else
        begin
            cmdResult.accept    <= !cmdProtected;
            cmdResult.violation <= cmdProtected;
        end
    end

    // ========================================================
    // register values for the rest of the flash module
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            configValue  <= flash_prot_pkg::CONFIG_RESET;
            protectValue <= flash_prot_pkg::PROTECT_RESET;
        end
        else
        begin
            configValue  <= configRead;
            protectValue <= next_protect;
        end
    end

endmodule // flash_config_protection_regs

// [flash_config_protection_regs_properties.sv]
// flash_config_protection_regs_properties: port-level checks of the flash
// config and protection registers; assumes one clock and sync reset.
`timescale 1ns/1ps

module flash_config_protection_regs_properties
(
    // clock and reset
    input wire logic                            clk,
    input wire logic                            rst_n,
    // apb
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [7:0]                      paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic                            pready,
    input wire logic [31:0]                     prdata,
    input wire logic                            pslverr,
    // neighbouring state and outputs
    input wire logic [1:0]                      backdoorEnableField,
    input wire logic                            bufferEmptyFlag,
    input wire logic                            allCompleteFlag,
    input wire logic                            bufferEmptyIrq,
    input wire logic                            completeIrq,
    input wire logic                            arrayWrite,
    input wire logic                            keyWordWrite,
    input wire logic                            cmdSequenceStart,
    input wire logic                            readDataInvalid,
    input wire flash_prot_pkg::cmd_request_type cmdRequest,
    input wire flash_prot_pkg::cmd_result_type  cmdResult,
    input wire logic [7:0]                      configValue,
    input wire flash_prot_pkg::protect_reg_type protectValue
);
    // ====================================
    // helpers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic cfgWr;
    logic mapped;
    // configValue lags the register by one cycle, hence the two-cycle looks
    assign cfgWr = psel && penable && pready && pwrite && paddr == flash_prot_pkg::CONFIG_ADDR;
    assign mapped = paddr == flash_prot_pkg::CONFIG_ADDR || paddr == flash_prot_pkg::PROTECT_ADDR;

    // ====================================
    // assertions
    cfg_enables_a: assert property (cfgWr |-> ##2 configValue[7:6] == $past(pwdata[7:6], 2)
        && configValue[4:0] == 5'h0) else $error("config enables not written");
    key_gate_a: assert property (cfgWr |-> ##2 configValue[5] ==
        ($past(backdoorEnableField, 2) == 2'b10 ? $past(pwdata[5], 2) : $past(configValue[5], 2)))
        else $error("key access gate broken");
    irq_follow_a: assert property (bufferEmptyIrq == (configValue[7] && $past(bufferEmptyFlag))
        && completeIrq == (configValue[6] && $past(allCompleteFlag))) else $error("irq wrong");
    route_a: assert property ($past(rst_n) |-> readDataInvalid == configValue[5]
        && keyWordWrite == ($past(arrayWrite) && configValue[5])
        && cmdSequenceStart == ($past(arrayWrite) && !configValue[5])) else $error("routing wrong");
    polarity_once_a: assert property ($past(rst_n) |-> !$rose(protectValue.polarity))
        else $error("polarity rose");
    low_frozen_a: assert property ($past(rst_n) && !$past(protectValue.lowerDisable)
        |-> $stable(protectValue.lowerSize)) else $error("lower size changed");
    up_frozen_a: assert property ($past(rst_n) && !$past(protectValue.upperDisable)
        |-> $stable(protectValue.upperSize)) else $error("upper size changed");
    prot_read_a: assert property (pready && !pwrite && paddr == flash_prot_pkg::PROTECT_ADDR
        |-> prdata == {24'h0, protectValue} && !pslverr) else $error("protect read wrong");
    unmapped_a: assert property (pready |-> pslverr == !mapped
        && (mapped || prdata == 32'h0)) else $error("unmapped access wrong");
    mass_erase_a: assert property (cmdRequest.valid && cmdRequest.massErase |=>
        cmdResult.accept == ($past(protectValue.polarity) && $past(protectValue.upperDisable)
        && $past(protectValue.lowerDisable))) else $error("mass erase gate wrong");
    cmd_answer_a: assert property ($past(rst_n) && cmdRequest.valid |=>
        cmdResult.accept != cmdResult.violation) else $error("command unanswered");

    // ====================================
    // covers
    key_set_c: cover property (cfgWr && backdoorEnableField == 2'b10 && pwdata[5]);
    mass_ok_c: cover property (cmdRequest.valid && cmdRequest.massErase ##1 cmdResult.accept);
    viol_c: cover property (cmdResult.violation);
    unmapped_c: cover property (pready && pslverr);
endmodule // flash_config_protection_regs_properties

bind flash_config_protection_regs flash_config_protection_regs_properties
    u_flash_config_protection_regs_properties
(
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .backdoorEnableField(backdoorEnableField), .bufferEmptyFlag(bufferEmptyFlag),
    .allCompleteFlag(allCompleteFlag), .bufferEmptyIrq(bufferEmptyIrq),
    .completeIrq(completeIrq), .arrayWrite(arrayWrite), .keyWordWrite(keyWordWrite),
    .cmdSequenceStart(cmdSequenceStart), .readDataInvalid(readDataInvalid),
    .cmdRequest(cmdRequest), .cmdResult(cmdResult), .configValue(configValue),
    .protectValue(protectValue)
);

// [flash_config_protection_regs_tb_top.sv]
// flash_config_protection_regs_tb_top: self-checking bench that drives
// every port of the register block; expected results queue for a monitor.
`timescale 1ns/1ps

module flash_config_protection_regs_tb_top;
    // ====================================
    // signals
    localparam logic [7:0] CFG = flash_prot_pkg::CONFIG_ADDR;
    localparam logic [7:0] PRT = flash_prot_pkg::PROTECT_ADDR;
    logic                            clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]                      paddr, storedProtectByte, configValue, expProt, w;
    logic [31:0]                     pwdata, prdata;
    logic [1:0]                      backdoorEnableField;
    logic                            bufferEmptyFlag, allCompleteFlag, arrayWrite;
    logic                            bufferEmptyIrq, completeIrq, keyWordWrite;
    logic                            cmdSequenceStart, readDataInvalid;
    flash_prot_pkg::cmd_request_type cmdRequest;
    flash_prot_pkg::cmd_result_type  cmdResult;
    flash_prot_pkg::protect_reg_type protectValue;
    logic [32:0]                     rdq [$];
    logic                            cmq [$];
    logic                            cmdViol;
    logic [15:0]                     addrs [10] = '{16'hf7ff, 16'hf800, 16'hc000, 16'hbfff,
        16'h4000, 16'h3fff, 16'h43ff, 16'h4400, 16'h5fff, 16'h6000};
    int                              n_fail, n_compared;

    flash_config_protection_regs u_flash_config_protection_regs
    (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .backdoorEnableField(backdoorEnableField), .bufferEmptyFlag(bufferEmptyFlag),
        .allCompleteFlag(allCompleteFlag), .storedProtectByte(storedProtectByte),
        .bufferEmptyIrq(bufferEmptyIrq), .completeIrq(completeIrq), .arrayWrite(arrayWrite),
        .keyWordWrite(keyWordWrite), .cmdSequenceStart(cmdSequenceStart),
        .readDataInvalid(readDataInvalid), .cmdRequest(cmdRequest), .cmdResult(cmdResult),
        .configValue(configValue), .protectValue(protectValue)
    );

    // ====================================
    // reference model: only adds protection, illegal writes dropped whole
    function automatic logic [7:0] prot_next(input logic [7:0] o, input logic [7:0] d);
        logic [7:0] n;
        logic       ok;
        n = {o[7] & d[7], o[6], d[5], o[5] ? d[4:3] : o[4:3], d[2], o[2] ? d[1:0] : o[1:0]};
        if (!o[7]) ok = n[5] >= o[5] && n[2] >= o[2];
        else if (n[7]) ok = n[5] <= o[5] && n[2] <= o[2];
        else ok = (n[5] || o[5]) && (n[2] || o[2]);
        return ok ? n : o;
    endfunction

    // polarity low turns the enabled ranges into the only writable holes
    function automatic logic is_prot(input logic [7:0] p, input logic [15:0] a);
        logic hit;
        hit = (!p[5] && {1'b0, a} >= 17'h1_0000 - (17'h0_0800 << p[4:3])) || (!p[2]
            && {1'b0, a} >= 17'h0_4000 && {1'b0, a} < 17'h0_4000 + (17'h0_0400 << p[1:0]));
        return p[7] ? hit : !hit;
    endfunction

    // ====================================
    // drivers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        if (!wr) rdq.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        {psel, penable} <= 2'b00;
        if (n >= 50) n_fail++;
    endtask

    task automatic cmd(input logic me, input logic [15:0] a, input logic viol);
        @(posedge clk);
        cmdRequest <= '{valid: 1'b1, massErase: me, addr: a};
        cmq.push_back(viol);
        @(posedge clk);
        cmdRequest.valid <= 1'b0;
    endtask

    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
        n_compared++;
        if (s !== e) begin n_fail++; $display("MISMATCH read exp %h seen %h", e, s); end
    endtask

    task automatic cmp_cmd(input logic [1:0] e, input logic [1:0] s);
        n_compared++;
        if (s !== e) begin n_fail++; $display("MISMATCH cmdResult exp %b seen %b", e, s); end
    endtask

    task automatic conclude();
        if (rdq.size() + cmq.size() != 0) n_fail++;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ====================================
    // clock, random side traffic, monitor, watchdog
    initial begin clk = 1'b0; forever #12.5 clk = ~clk; end

    always @(posedge clk)
    begin
        bufferEmptyFlag <= 1'($urandom);
        allCompleteFlag <= 1'($urandom);
        arrayWrite      <= ($urandom % 4) == 0;
    end

    // results are taken the edge after they appear, before the next update lands
    always @(posedge clk)
    begin
        if (rst_n && pready && !pwrite)
            cmp_rd(rdq.size() ? rdq.pop_front() : 'x, {pslverr, prdata});
        if (rst_n && (cmdResult.accept || cmdResult.violation))
        begin
            cmdViol = cmq.size() ? cmq.pop_front() : 1'bx;
            cmp_cmd({!cmdViol, cmdViol}, cmdResult);
        end
    end

    initial begin repeat (20000) @(posedge clk); n_fail++; conclude(); end

    // ====================================
    // main sequence
    initial
    begin
        void'($urandom(84));
        {rst_n, psel, penable, pwrite, paddr, pwdata, backdoorEnableField} = '0;
        cmdRequest = '0;
        storedProtectByte = 8'hff;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, CFG, 0, 33'h0_0000_0000);
        apb(0, 8'h14, 0, 33'h1_0000_0000);
        for (int k = 0; k < 4; k++)
        begin
            backdoorEnableField <= 2'(k);
            apb(1, CFG, 32'hffff_ffff, 0);
            apb(0, CFG, 0, {25'h0, 2'b11, k >= 2, 5'h0});
            repeat (8) @(posedge clk);
        end
        backdoorEnableField <= 2'b10;
        apb(1, CFG, 32'h0000_0000, 0);
        apb(0, CFG, 0, 33'h0_0000_0000);
        for (int r = 0; r < 2; r++)
        begin
            expProt = storedProtectByte;
            apb(0, PRT, 0, {25'h0, expProt});
            for (int i = 0; i < 10; i++)
            begin
                w = 8'($urandom);
                apb(1, PRT, {24'h0, w}, 0);
                expProt = prot_next(expProt, w);
                apb(0, PRT, 0, {25'h0, expProt});
                foreach (addrs[j]) cmd(0, addrs[j], is_prot(expProt, addrs[j]));
                w = 8'($urandom);
                cmd(0, {w, ~w}, is_prot(expProt, {w, ~w}));
                cmd(1, 16'h0000, !(expProt[7] && expProt[5] && expProt[2]));
            end
            repeat (2) @(posedge clk);
            rst_n <= 1'b0;
            storedProtectByte <= 8'($urandom) | 8'h40;
            repeat (5) @(posedge clk);
            rst_n <= 1'b1;
            repeat (3) @(posedge clk);
        end
        conclude();
    end
endmodule // flash_config_protection_regs_tb_top
